// file: rpc_top.sv
// Configuration-mode controller: strap decode, pin lookup and lane registers.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
// Contract
// - strap low pin, high slave, open master.
// - master mode fetches registers from EEPROM.
// - four-level input resolves at three thresholds.
// - four levels interpreted only in pin mode; the code reads the strap and idle threshold pins at four levels in every mode.
// - pin settings chosen separately per side.
// - nonzero de-emphasis sets its paired amplitude.
// - de-emphasis pins select sixteen amplitude pairs.
// - idle threshold follows its pin.
// - serial mode programs each lane separately.
// - serial strap gives registers control immediately.
// - eq and de-emphasis pins become address.
// - other pins ignored after write plus override.
// - power-up or strap low restores defaults.
// - reset input keeps registers in serial mode.
// - register equalizer code is eight bits.
// - eq pins map to sixteen fixed codes.
// - management clock near 400 kHz.
module rpc_top #(
  parameter int NUM_CH = 4
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Pins: four-level comparators and the device reset.
  input wire logic [rpc_pkg::NUM_PIN*3-1:0] lvl_cmp_i,
  input wire logic reset_pin_i,
  // EEPROM word fetch.
  output logic ee_req_o,
  output logic [7:0] ee_addr_o,
  output logic ee_clk_o,
  input wire logic [31:0] ee_data_i,
  input wire logic ee_ack_i,
  // Settings to the signal path, slave address, mode and low-power flag.
  output logic [NUM_CH*8-1:0] eq_o,
  output logic [NUM_CH*4-1:0] vod_o,
  output logic [NUM_CH*2-1:0] dem_o,
  output logic [NUM_CH-1:0] term_dis_o,
  output logic [1:0] idle_th_o,
  output logic [3:0] slave_addr_o,
  output logic [1:0] mode_o,
  output logic low_power_o
);

  if (NUM_CH < 1 || NUM_CH > 8) begin : g_chk
    $error("NUM_CH must lie in 1 to 8");
  end

  typedef struct packed {
    logic rp_meta;
    logic rp_sync;
    rpc_pkg::rpc_mode_e mode;
    logic [NUM_CH-1:0][31:0] ch;
    logic [31:0] ctrl;
    logic th_written;
    logic th_ignore;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    rpc_pkg::rpc_load_e ld;
    logic [2:0] ld_idx;
    logic ld_done;
    logic ee_req;
    logic [5:0] clk_cnt;
    logic ee_clk;
    logic [NUM_CH-1:0][7:0] eq;
    logic [NUM_CH-1:0][3:0] output_amplitude;
    logic [NUM_CH-1:0][1:0] deemphasis_level;
    logic [NUM_CH-1:0] tdis;
    logic [1:0] idle_th;
    logic [3:0] addr;
    logic low_power;
  } rpc_top_s;

  rpc_top_s s;
  rpc_top_s n;
  logic wr_en;
  logic rd_hit;
  logic [1:0] lvl [rpc_pkg::NUM_PIN];
  logic [7:0] pin_eq [2];
  logic [3:0] pin_vod [2];
  logic [1:0] pin_dem [2];
  logic [3:0] addr_pins;

  for (genvar p = 0; p < rpc_pkg::NUM_PIN; p++) begin : g_dec
    rpc_lvl_dec u_dec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cmp_i(lvl_cmp_i[p*3 +: 3]),
      .lvl_o(lvl[p])
    );
  end

  // Side 0 is the D side, side 1 the S side.
  for (genvar sd = 0; sd < 2; sd++) begin : g_side
    rpc_pin_lut u_lut (
      .eq_hi_i(lvl[rpc_pkg::EQ_LEVEL_DSIDE_HI + 2*sd]),
      .eq_lo_i(lvl[rpc_pkg::EQ_LEVEL_DSIDE_LO + 2*sd]),
      .dem_hi_i(lvl[rpc_pkg::DEEMPH_LEVEL_DSIDE_HI + 2*sd]),
      .dem_lo_i(lvl[rpc_pkg::DEEMPH_LEVEL_DSIDE_LO + 2*sd]),
      .eq_o(pin_eq[sd]),
      .vod_o(pin_vod[sd]),
      .dem_o(pin_dem[sd])
    );
  end

  // Outside pin mode only the upper half of each level counts, as a plain bit.
  assign addr_pins = {lvl[rpc_pkg::DEEMPH_LEVEL_SSIDE_LO][1],
                      lvl[rpc_pkg::DEEMPH_LEVEL_DSIDE_LO][1],
                      lvl[rpc_pkg::EQ_LEVEL_SSIDE_LO][1],
                      lvl[rpc_pkg::EQ_LEVEL_DSIDE_LO][1]};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] ch_addr(input int c);
    return 8'(int'(rpc_pkg::CH_BASE) + 4 * c);
  endfunction

  always_comb begin
    n = s;
    wr_en = 1'b0;
    rd_hit = 1'b0;
    n.rp_meta = reset_pin_i;
    n.rp_sync = s.rp_meta;
    n.low_power = s.rp_sync;
    case (lvl[rpc_pkg::SERIAL_CONFIG_STRAP])
      rpc_pkg::LV_1: n.mode = rpc_pkg::MODE_SLAVE;
      rpc_pkg::LV_F: n.mode = rpc_pkg::MODE_MASTER;
      default: n.mode = rpc_pkg::MODE_PIN;
    endcase
    // Write address and data are held independently and meet here.
    if (s_axi_awvalid_i && s.aw_rdy) begin
      n.aw_hold = 1'b1;
      n.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s.w_rdy) begin
      n.w_hold = 1'b1;
      n.wdata = s_axi_wdata_i;
      n.wstrb = s_axi_wstrb_i;
    end
    if (s.bvalid && s_axi_bready_i) begin
      n.bvalid = 1'b0;
    end
    wr_en = n.aw_hold && n.w_hold && !n.bvalid;
    if (wr_en) begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = rpc_pkg::RESP_OKAY;
      if (n.aw_addr == rpc_pkg::CTRL_OFS) begin
        n.ctrl = merge(s.ctrl, n.wdata, n.wstrb);
        if (n.wstrb[0]) begin
          n.th_written = 1'b1;
        end
      end else if (n.aw_addr != rpc_pkg::STAT_OFS) begin
        n.bresp = rpc_pkg::RESP_SLVERR;
        for (int c = 0; c < NUM_CH; c++) begin
          if (n.aw_addr == ch_addr(c)) begin
            n.ch[c] = merge(s.ch[c], n.wdata, n.wstrb);
            n.bresp = rpc_pkg::RESP_OKAY;
          end
        end
      end
    end
    if (s.rvalid && s_axi_rready_i) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s.ar_rdy) begin
      n.rvalid = 1'b1;
      n.rresp = rpc_pkg::RESP_OKAY;
      n.rdata = '0;
      if (s_axi_araddr_i == rpc_pkg::CTRL_OFS) begin
        n.rdata = s.ctrl;
      end else if (s_axi_araddr_i == rpc_pkg::STAT_OFS) begin
        n.rdata = {23'h0, s.low_power, s.ld_done, s.th_ignore, s.addr, s.mode};
      end else begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (s_axi_araddr_i == ch_addr(c)) begin
            n.rdata = s.ch[c];
            rd_hit = 1'b1;
          end
        end
        if (!rd_hit) begin
          n.rresp = rpc_pkg::RESP_SLVERR;
        end
      end
    end
    // EEPROM fetch starts on every entry into master mode.
    n.ee_req = 1'b0;
    case (s.ld)
      rpc_pkg::LD_IDLE: begin
        if (n.mode == rpc_pkg::MODE_MASTER && s.mode != rpc_pkg::MODE_MASTER) begin
          n.ld = rpc_pkg::LD_FETCH;
          n.ld_idx = 3'h0;
          n.ld_done = 1'b0;
        end
      end
      rpc_pkg::LD_FETCH: begin
        if (ee_ack_i) begin
          n.ch[s.ld_idx] = ee_data_i;
          if (int'(s.ld_idx) == NUM_CH - 1) begin
            n.ld = rpc_pkg::LD_DONE;
            n.ld_done = 1'b1;
          end else begin
            n.ld_idx = s.ld_idx + 3'h1;
          end
        end
      end
      rpc_pkg::LD_DONE: n.ld = rpc_pkg::LD_DONE;
      default: n.ld = rpc_pkg::LD_IDLE;
    endcase
    if (n.mode != rpc_pkg::MODE_MASTER) begin
      n.ld = rpc_pkg::LD_IDLE;
    end
    if (n.ld == rpc_pkg::LD_FETCH) begin
      n.ee_req = 1'b1;
      if (int'(s.clk_cnt) == rpc_pkg::SMB_HALF_CYC - 1) begin
        n.clk_cnt = 6'h0;
        n.ee_clk = !s.ee_clk;
      end else begin
        n.clk_cnt = s.clk_cnt + 6'h1;
      end
    end else begin
      n.clk_cnt = 6'h0;
      n.ee_clk = 1'b1;
    end
    // The latch outlives a later clear of the override bit until pin mode.
    if (n.th_written && n.ctrl[rpc_pkg::OVR_BIT]) begin
      n.th_ignore = 1'b1;
    end
    // The reset pin touches no register here, so contents survive it.
    if (n.mode == rpc_pkg::MODE_PIN) begin
      n.ch = {NUM_CH{rpc_pkg::CH_RST}};
      n.ctrl = rpc_pkg::CTRL_RST;
      n.th_written = 1'b0;
      n.th_ignore = 1'b0;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (s.mode == rpc_pkg::MODE_PIN) begin
        n.eq[c] = pin_eq[c % 2];
        n.output_amplitude[c] = pin_vod[c % 2];
        n.deemphasis_level[c] = pin_dem[c % 2];
        n.tdis[c] = 1'b0;
      end else begin
        n.eq[c] = s.ch[c][rpc_pkg::EQ_LSB +: 8];
        n.output_amplitude[c] = s.ch[c][rpc_pkg::VOD_LSB +: 4];
        n.deemphasis_level[c] = s.ch[c][rpc_pkg::DEM_LSB +: 2];
        n.tdis[c] = s.ch[c][rpc_pkg::TDIS_BIT];
      end
    end
    if (s.th_ignore) begin
      n.idle_th = s.ctrl[rpc_pkg::TH_LSB +: 2];
    end else begin
      n.idle_th = lvl[rpc_pkg::IDLE_THRESHOLD_PIN];
    end
    n.addr = (s.mode == rpc_pkg::MODE_PIN) ? 4'h0 : addr_pins;
    n.aw_rdy = !n.aw_hold && !n.bvalid;
    n.w_rdy = !n.w_hold && !n.bvalid;
    n.ar_rdy = !n.rvalid;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.ch <= {NUM_CH{rpc_pkg::CH_RST}};
      s.ctrl <= rpc_pkg::CTRL_RST;
      s.ee_clk <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready_o = s.aw_rdy;
  assign s_axi_wready_o = s.w_rdy;
  assign s_axi_bresp_o = s.bresp;
  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_arready_o = s.ar_rdy;
  assign s_axi_rdata_o = s.rdata;
  assign s_axi_rresp_o = s.rresp;
  assign s_axi_rvalid_o = s.rvalid;
  assign ee_req_o = s.ee_req;
  assign ee_addr_o = {5'h0, s.ld_idx};
  assign ee_clk_o = s.ee_clk;
  assign eq_o = s.eq;
  assign vod_o = s.output_amplitude;
  assign dem_o = s.deemphasis_level;
  assign term_dis_o = s.tdis;
  assign idle_th_o = s.idle_th;
  assign slave_addr_o = s.addr;
  assign mode_o = s.mode;
  assign low_power_o = s.low_power;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  strap_slave_a: assert property (lvl[0] == rpc_pkg::LV_1 |=> mode_o == 2'h1)
    else $error("strap high did not select slave mode");
  strap_open_a: assert property (lvl[0] == rpc_pkg::LV_F |=> mode_o == 2'h2)
    else $error("open strap did not select master mode");
  pin_eq_a: assert property (s.mode == rpc_pkg::MODE_PIN |=>
      eq_o[7:0] == $past(pin_eq[0]) && eq_o[15:8] == $past(pin_eq[1]))
    else $error("pin equalizer code differs from its side lookup");
  dem_pair_a: assert property (s.mode == rpc_pkg::MODE_PIN && pin_dem[0] != 2'h0
      |=> vod_o[3:0] >= 4'h8 && dem_o[1:0] != 2'h0)
    else $error("de-emphasis without its paired amplitude");
  reg_ctrl_a: assert property (s.mode != rpc_pkg::MODE_PIN |=>
      eq_o[7:0] == $past(s.ch[0][7:0]) && term_dis_o[1] == $past(s.ch[1][16]))
    else $error("serial mode output not taken from lane register");
  addr_pins_a: assert property (s.mode != rpc_pkg::MODE_PIN |=>
      slave_addr_o == $past(addr_pins))
    else $error("slave address does not follow the pins");
  strap_clear_a: assert property (s.mode == rpc_pkg::MODE_PIN |->
      s.ch[0] == rpc_pkg::CH_RST && !s.th_ignore)
    else $error("registers not at default in pin mode");
  reset_keep_a: assert property (s.rp_sync && s.mode != rpc_pkg::MODE_PIN &&
      n.mode != rpc_pkg::MODE_PIN && !wr_en && s.ld != rpc_pkg::LD_FETCH |=> $stable(s.ch))
    else $error("reset input disturbed serial registers");
  override_a: assert property (s.th_ignore |=> idle_th_o == $past(s.ctrl[5:4]))
    else $error("overridden threshold not taken from register");
  idle_pin_a: assert property (!s.th_ignore |=> idle_th_o == $past(lvl[1]))
    else $error("idle threshold does not follow its pin");
  ee_fetch_a: assert property (s.ld == rpc_pkg::LD_FETCH && ee_ack_i &&
      n.mode == rpc_pkg::MODE_MASTER |=> s.ch[$past(s.ld_idx)] == $past(ee_data_i))
    else $error("fetched word not stored");
  clk_half_a: assert property ($changed(ee_clk_o) && ee_req_o |=>
      (!ee_req_o || $stable(ee_clk_o))[*8])
    else $error("management clock half period too short");

  serial_to_pin_c: cover property (s.mode == rpc_pkg::MODE_SLAVE ##1 s.mode == rpc_pkg::MODE_PIN);
  load_done_c: cover property (s.ld == rpc_pkg::LD_DONE);
  override_c: cover property (s.th_ignore);
  write_c: cover property (wr_en && s.mode == rpc_pkg::MODE_SLAVE);

endmodule

// file: rpc_pkg.sv
// Shared constants, tables and types of the repeater configuration controller.
package rpc_pkg;

  // Four-level pin codes, ordered by rising pin voltage.
  localparam logic [1:0] LV_0 = 2'h0;
  localparam logic [1:0] LV_R = 2'h1;
  localparam logic [1:0] LV_F = 2'h2;
  localparam logic [1:0] LV_1 = 2'h3;

  // Positions of the four-level pins on the comparator bus.
  localparam int NUM_PIN = 10;
  localparam int SERIAL_CONFIG_STRAP = 0;
  localparam int IDLE_THRESHOLD_PIN = 1;
  localparam int EQ_LEVEL_DSIDE_HI = 2;
  localparam int EQ_LEVEL_DSIDE_LO = 3;
  localparam int EQ_LEVEL_SSIDE_HI = 4;
  localparam int EQ_LEVEL_SSIDE_LO = 5;
  localparam int DEEMPH_LEVEL_DSIDE_HI = 6;
  localparam int DEEMPH_LEVEL_DSIDE_LO = 7;
  localparam int DEEMPH_LEVEL_SSIDE_HI = 8;
  localparam int DEEMPH_LEVEL_SSIDE_LO = 9;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] CH_BASE = 8'h10;

  // Lane register fields.
  localparam int EQ_LSB = 0;
  localparam int VOD_LSB = 8;
  localparam int DEM_LSB = 12;
  localparam int TDIS_BIT = 16;
  // Control register fields.
  localparam int OVR_BIT = 0;
  localparam int TH_LSB = 4;

  // Values after reset.
  localparam logic [31:0] CH_RST = 32'h0000_0A00;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pin lookup tables, indexed by {hi level, lo level}.
  localparam logic [15:0][7:0] EQ_TBL = 128'hFFBF7FAA3F2F1F550F0B150703020100;
  // Output amplitude in units of 0.1 Vpp.
  localparam logic [15:0][3:0] VOD_TBL = 64'hCCCCBBBAAA999886;
  // De-emphasis code: 0 none, 1 -3.5 dB, 2 -6 dB, 3 -9 dB.
  localparam logic [15:0][1:0] DEM_TBL = 32'hE4924910;

  // Management clock of the EEPROM fetch.
  localparam int CLK_KHZ = 25000;
  localparam int SMB_KHZ = 400;
  localparam int SMB_HALF_CYC = CLK_KHZ / (2 * SMB_KHZ);

  typedef enum logic [1:0] {MODE_PIN, MODE_SLAVE, MODE_MASTER} rpc_mode_e;
  typedef enum logic [1:0] {LD_IDLE, LD_FETCH, LD_DONE} rpc_load_e;

endpackage

// file: rpc_lvl_dec.sv
// Four-level pin decoder: synchronises the comparator outputs and resolves a level.
`timescale 1ns/1ns
module rpc_lvl_dec (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Comparators above 0.2, 0.5 and 0.8 of supply.
  input wire logic [2:0] cmp_i,
  // Decoded level.
  output logic [1:0] lvl_o
);

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic [1:0] lvl;
  } rpc_dec_s;

  rpc_dec_s s;
  rpc_dec_s n;

  // The highest tripped comparator wins, so a bubble cannot pick a lower level.
  always_comb begin
    n = s;
    n.meta = cmp_i;
    n.sync = s.meta;
    if (s.sync[2]) begin
      n.lvl = rpc_pkg::LV_1;
    end else if (s.sync[1]) begin
      n.lvl = rpc_pkg::LV_F;
    end else if (s.sync[0]) begin
      n.lvl = rpc_pkg::LV_R;
    end else begin
      n.lvl = rpc_pkg::LV_0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign lvl_o = s.lvl;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  level_float_a: assert property (s.sync == 3'h3 |=> lvl_o == rpc_pkg::LV_F)
    else $error("mid comparators did not decode to F");
  level_top_a: assert property (s.sync[2] |=> lvl_o == rpc_pkg::LV_1)
    else $error("top comparator did not decode to 1");

endmodule

// file: rpc_pin_lut.sv
// Pin-mode lookup of equalizer code, output amplitude and de-emphasis for one side.
`timescale 1ns/1ns
module rpc_pin_lut (
  // Decoded pin levels.
  input wire logic [1:0] eq_hi_i,
  input wire logic [1:0] eq_lo_i,
  input wire logic [1:0] dem_hi_i,
  input wire logic [1:0] dem_lo_i,
  // Settings.
  output logic [7:0] eq_o,
  output logic [3:0] vod_o,
  output logic [1:0] dem_o
);

  assign eq_o = rpc_pkg::EQ_TBL[{eq_hi_i, eq_lo_i}];
  // Amplitude and de-emphasis share one index, so they always move as a pair.
  assign vod_o = rpc_pkg::VOD_TBL[{dem_hi_i, dem_lo_i}];
  assign dem_o = rpc_pkg::DEM_TBL[{dem_hi_i, dem_lo_i}];

endmodule

// file: rpc_ee_model.sv
// Configuration EEPROM model answering the controller's word fetch.
`timescale 1ns/1ns
module rpc_ee_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Word fetch port and answer delay in cycles.
  input wire logic ee_req_i,
  input wire logic [7:0] ee_addr_i,
  input wire logic [7:0] dly_i,
  output logic [31:0] ee_data_o,
  output logic ee_ack_o
);
  logic [7:0] cnt_r;
  // Outside an ack the data toggles, so a stale word can never pass as a fresh one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 8'h00;
      ee_ack_o <= 1'b0;
      ee_data_o <= 32'h00000000;
    end else if (ee_req_i && !ee_ack_o && cnt_r >= dly_i) begin
      cnt_r <= 8'h00;
      ee_ack_o <= 1'b1;
      ee_data_o <= 32'h00002900 + 32'(ee_addr_i + 8'h01) * 32'h11;
    end else begin
      cnt_r <= ee_req_i ? cnt_r + 8'h01 : 8'h00;
      ee_ack_o <= 1'b0;
      ee_data_o <= ~ee_data_o;
    end
  end
endmodule

// file: testbench.sv
// Self-checking bench of the repeater configuration controller.
`timescale 1ns/1ns
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [29:0] cmp = 30'h00000000;
  logic rpin = 1'b0;
  logic [7:0] dly = 8'h64;
  logic awready, wready, bvalid, arready, rvalid, ee_req, ee_clk, ee_ack, low_pw;
  logic [1:0] bresp, rresp, idle_th, mode;
  logic [31:0] rdata, ee_data, eq;
  logic [7:0] ee_addr, deemphasis_level;
  logic [15:0] output_amplitude;
  logic [3:0] tdis, saddr;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;

  rpc_top #(.NUM_CH(4)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .lvl_cmp_i(cmp), .reset_pin_i(rpin),
    .ee_req_o(ee_req), .ee_addr_o(ee_addr), .ee_clk_o(ee_clk), .ee_data_i(ee_data),
    .ee_ack_i(ee_ack), .eq_o(eq), .vod_o(output_amplitude), .dem_o(deemphasis_level), .term_dis_o(tdis),
    .idle_th_o(idle_th), .slave_addr_o(saddr), .mode_o(mode), .low_power_o(low_pw));

  rpc_ee_model ee_u (.clk_i(clk_i), .rst_i(rst_i), .ee_req_i(ee_req), .ee_addr_i(ee_addr),
    .dly_i(dly), .ee_data_o(ee_data), .ee_ack_o(ee_ack));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic report_and_stop;
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [2:0] therm(input logic [1:0] l);
    return (l == rpc_pkg::LV_1) ? 3'h7 : (l == rpc_pkg::LV_F) ? 3'h3 : {2'h0, l[0]};
  endfunction

  task automatic lv(input int p, input logic [1:0] l);
    cmp[p*3 +: 3] <= therm(l);
  endtask

  // Pin to level takes 3 cycles, level to mode 1 and mode to outputs 1.
  task automatic settle;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // Outputs are sampled at the falling edge, which sees what the next rising edge takes.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic aw_t, w_t, b_t;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk_i);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      rs = bresp;
      @(posedge clk_i);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (b_t !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ar_t, r_t;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk_i);
      ar_t = arvalid & arready;
      r_t = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge clk_i);
      if (ar_t) arvalid <= 1'b0;
    end while (r_t !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic lane(input int c, input logic [7:0] e, input logic [3:0] v, input logic [1:0] m);
    chk("eq", eq[c*8 +: 8], e);
    chk("vod", output_amplitude[c*4 +: 4], v);
    chk("dem", deemphasis_level[c*2 +: 2], m);
  endtask

  task automatic sc_pin;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge clk_i);
    lv(rpc_pkg::EQ_LEVEL_DSIDE_HI, rpc_pkg::LV_F);
    lv(rpc_pkg::EQ_LEVEL_SSIDE_HI, rpc_pkg::LV_1);
    lv(rpc_pkg::EQ_LEVEL_SSIDE_LO, rpc_pkg::LV_1);
    lv(rpc_pkg::DEEMPH_LEVEL_DSIDE_HI, rpc_pkg::LV_R);
    lv(rpc_pkg::DEEMPH_LEVEL_DSIDE_LO, rpc_pkg::LV_R);
    lv(rpc_pkg::DEEMPH_LEVEL_SSIDE_HI, rpc_pkg::LV_1);
    lv(rpc_pkg::DEEMPH_LEVEL_SSIDE_LO, rpc_pkg::LV_1);
    lv(rpc_pkg::IDLE_THRESHOLD_PIN, rpc_pkg::LV_R);
    settle();
    for (int c = 0; c < 4; c += 2) begin
      lane(c, 8'h55, 4'h9, 2'h2);
      lane(c + 1, 8'hFF, 4'hC, 2'h3);
    end
    chk("mode", mode, 32'h0);
    chk("addr", saddr, 32'h0);
    chk("idle", idle_th, rpc_pkg::LV_R);
    chk("tdis", tdis, 32'h0);
    wr(rpc_pkg::CH_BASE, 32'h00001234, rs);
    rd(rpc_pkg::CH_BASE, d, rs);
    chk("pinwr", d, rpc_pkg::CH_RST);
  endtask

  task automatic sc_slave;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge clk_i);
    lv(rpc_pkg::SERIAL_CONFIG_STRAP, rpc_pkg::LV_1);
    settle();
    chk("mode", mode, 32'h1);
    chk("addr", saddr, 32'hA);
    lane(0, 8'h00, 4'hA, 2'h0);
    wr(rpc_pkg::CH_BASE, 32'h00012C5A, rs);
    chk("bresp", rs, rpc_pkg::RESP_OKAY);
    wr(rpc_pkg::CH_BASE + 8'h04, 32'h00003BA5, rs);
    settle();
    lane(0, 8'h5A, 4'hC, 2'h2);
    lane(1, 8'hA5, 4'hB, 2'h3);
    chk("tdis", tdis, 32'h1);
    chk("idle", idle_th, rpc_pkg::LV_R);
    wr(rpc_pkg::CTRL_OFS, 32'h00000031, rs);
    @(posedge clk_i);
    lv(rpc_pkg::IDLE_THRESHOLD_PIN, rpc_pkg::LV_F);
    settle();
    chk("ovr", idle_th, 32'h3);
    rd(8'hFC, d, rs);
    chk("resp", rs, rpc_pkg::RESP_SLVERR);
    wr(8'hFC, 32'h00000000, rs);
    chk("bresp", rs, rpc_pkg::RESP_SLVERR);
    @(posedge clk_i);
    rpin <= 1'b1;
    settle();
    chk("lowpw", low_pw, 32'h1);
    rd(rpc_pkg::CH_BASE, d, rs);
    chk("keep", d, 32'h00012C5A);
    @(posedge clk_i);
    rpin <= 1'b0;
    lv(rpc_pkg::SERIAL_CONFIG_STRAP, rpc_pkg::LV_0);
    settle();
    chk("idle", idle_th, rpc_pkg::LV_F);
    @(posedge clk_i);
    lv(rpc_pkg::SERIAL_CONFIG_STRAP, rpc_pkg::LV_1);
    settle();
    rd(rpc_pkg::CH_BASE, d, rs);
    chk("dflt", d, rpc_pkg::CH_RST);
  endtask

  task automatic sc_master;
    logic [31:0] d;
    logic [1:0] rs;
    logic e;
    int n;
    @(posedge clk_i);
    lv(rpc_pkg::SERIAL_CONFIG_STRAP, rpc_pkg::LV_F);
    n = 0;
    while (ee_req !== 1'b1) @(negedge clk_i);
    e = ee_clk;
    while (ee_clk === e) @(negedge clk_i);
    e = ee_clk;
    while (ee_clk === e) begin
      @(negedge clk_i);
      n++;
    end
    chk("smbclk", 32'(n >= 25 && n <= 44), 32'h1);
    while (ee_req === 1'b1) @(negedge clk_i);
    settle();
    for (int c = 0; c < 4; c++) lane(c, 8'(8'h11 * (c + 1)), 4'h9, 2'h2);
    // A second fetch with a prompt partner.
    @(posedge clk_i);
    dly <= 8'h00;
    lv(rpc_pkg::SERIAL_CONFIG_STRAP, rpc_pkg::LV_0);
    settle();
    @(posedge clk_i);
    lv(rpc_pkg::SERIAL_CONFIG_STRAP, rpc_pkg::LV_F);
    settle();
    while (ee_req === 1'b1) @(negedge clk_i);
    settle();
    lane(3, 8'h44, 4'h9, 2'h2);
    rd(rpc_pkg::STAT_OFS, d, rs);
    chk("done", d[7], 32'h1);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    sc_pin();
    sc_slave();
    sc_master();
    report_and_stop();
  end
endmodule
